// ### common/rss_pkg.sv
// How it works
// - Offset pins sampled only at boot
// - Grounded pin is one; address is 6 plus twice
// - Save copies system settings to a store kept over software reset, cleared by hardware reset
// - Twelve flash slots, one RAM slot
// - Each rail switched on or off independently
// - Out-of-range setpoint rejected with error
// - Path codes: 0 auto, 1 linear, 3 switcher
// - 32-bit condition word per rail
// - Bits 0,1,2: initializing, enabled, fault
// - Initializing bit means ready for enable
// - Enabled bit follows true output state
// - Bits 8-15 show adjustable path in use
// - Fault causes bits 18, 21; clear command
// - Current limit settable from 0A to 3A
// - Adjustable overcurrent holds limit, no fault
// - Pass-through overcurrent trips rail and latches
// - Overvoltage disconnects, reconnects, no fault
// - Overtemperature trips adjustable rail and latches
// - Sense mode setting with separate effective readback
// - Status pin high when adjustable rail on, else released
`default_nettype none
package rss_pkg;
   localparam logic [7:0] BASE_ADDR = 8'h06;
   localparam int unsigned OFS_SHIFT = 1;
   localparam int unsigned FLASH_SLOTS = 12;
   localparam int unsigned RAM_SLOTS = 1;
   localparam int unsigned SLOTS = FLASH_SLOTS + RAM_SLOTS;
   localparam logic [31:0] VSET_MIN_UV = 32'h0000_0000;
   localparam logic [31:0] VSET_MAX_UV = 32'h004c_4b40;
   localparam logic [31:0] VSET_RST_UV = 32'h0000_0000;
   localparam logic [31:0] ILIM_MAX_UA = 32'h002d_c6c0;
   localparam logic [1:0] PATH_AUTO = 2'h0;
   localparam logic [1:0] PATH_LINEAR = 2'h1;
   localparam logic [1:0] PATH_SWLIN = 2'h3;
   localparam logic [7:0] ACT_LINEAR = 8'h01;
   localparam logic [7:0] ACT_SWLIN = 8'h03;
   localparam int unsigned ST_INIT = 0;
   localparam int unsigned ST_EN = 1;
   localparam int unsigned ST_FAULT = 2;
   localparam int unsigned ST_HW_LSB = 8;
   localparam int unsigned ST_OC = 18;
   localparam int unsigned ST_OT = 21;
   localparam logic ADJ = 1'b0;
   localparam logic PASS = 1'b1;
   localparam logic SENSE_OFF = 1'b0;
   localparam logic SENSE_ON = 1'b1;
   localparam logic [2:0] SYS_SOFT_OFS = 3'h0;
   localparam logic [2:0] SYS_ROUTER = 3'h1;
   localparam logic [2:0] SYS_HEARTBEAT = 3'h2;
   localparam logic [2:0] SYS_BUS_RATE = 3'h3;
   localparam logic [2:0] SYS_PULLUP = 3'h4;
   localparam logic [2:0] SYS_BOOT_SLOT = 3'h5;
   localparam int unsigned SYS_FIELDS = 6;

   typedef enum logic [4:0] {
      OP_SWITCH = 5'h00, OP_VSET = 5'h01, OP_VGET = 5'h02, OP_ILIM = 5'h03,
      OP_ILIM_GET = 5'h04, OP_PATH_SET = 5'h05, OP_PATH_GET = 5'h06,
      OP_COND = 5'h07, OP_CLEAR = 5'h08, OP_SENSE_SET = 5'h09,
      OP_SENSE_GET = 5'h0a, OP_SENSE_STATE = 5'h0b, OP_SAVE = 5'h0c,
      OP_SYS_RESET = 5'h0d, OP_SYS_WR = 5'h0e, OP_SYS_RD = 5'h0f,
      OP_SLOT_LOAD = 5'h10, OP_SLOT_UNLOAD = 5'h11, OP_SLOT_STATE = 5'h12,
      OP_ADDR_GET = 5'h13
   } rss_op_t;

   typedef enum logic [1:0] {BS_RESET, BS_SAMPLE, BS_RUN} rss_boot_t;

   typedef struct packed {
      logic valid;
      rss_op_t op;
      logic rail;
      logic [31:0] data;
   } rss_cmd_t;

   typedef struct packed {
      logic valid;
      logic err;
      logic [31:0] data;
   } rss_rsp_t;

   typedef struct packed {
      logic [1:0] active;
      logic adj_oc;
      logic pass_oc;
      logic adj_ot;
      logic adj_ov;
      logic vin_high;
      logic stage_fault;
   } rss_ana_t;

   typedef logic [7:0] rss_sys_t [SYS_FIELDS];
endpackage : rss_pkg
`default_nettype wire

// ### rtl/rss_top.sv
`timescale 1ns/1ps
`default_nettype none
module rss_top
   import rss_pkg::*;
(
   input wire logic clk, // 125 MHz core clock
   input wire logic resetn, // Async reset, active low
   input wire logic [3:0] ofs_pin_lvl, // Offset pin levels, grounded reads 0
   input wire rss_cmd_t cmd, // Host command
   input wire rss_ana_t ana, // Power stage monitors
   output rss_rsp_t rsp, // Command answer
   output logic [7:0] net_addr, // Network address
   output logic [1:0] rail_drive, // Power stage enables
   output logic [31:0] vset_uv, // Adjustable setpoint
   output logic [31:0] ilim_adj_ua, // Adjustable current limit
   output logic [31:0] ilim_pass_ua, // Pass-through current limit
   output logic switcher_en, // Switcher stage on
   output logic limit_hold, // Lower voltage to hold current
   output logic adj_disconnect, // Overvoltage disconnect
   output logic sense_eff, // Effective remote sense
   output logic stat_o, // Status pin output value
   output logic stat_oe // Status pin drive enable
);

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic rst_n;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo,
                                     input logic [31:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction : in_range

   function automatic logic slot_ok(input logic [31:0] d);
      logic st;
      logic [7:0] idx;
      st = d[8];
      idx = d[7:0];
      slot_ok = st ? (idx < 8'(RAM_SLOTS)) : (idx < 8'(FLASH_SLOTS));
   endfunction : slot_ok

   function automatic logic [3:0] slot_bit(input logic [31:0] d);
      slot_bit = d[8] ? 4'(FLASH_SLOTS) : d[3:0];
   endfunction : slot_bit

   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   logic go;
   logic on_adj;
   logic sw_reset;
   rss_boot_t boot_q;

   assign go = cmd.valid && (boot_q == BS_RUN);
   assign on_adj = cmd.rail == ADJ;
   assign sw_reset = go && cmd.op == OP_SYS_RESET;

   // ------------------------------------------------------------
   // Boot sequence and addressing
   // ------------------------------------------------------------
   logic [7:0] addr_q;
   rss_sys_t live_q;
   rss_sys_t nv_q;

   // A software reset walks the same path as a hardware one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_q <= BS_RESET;
      end else begin
         unique case (boot_q)
            BS_RESET: boot_q <= BS_SAMPLE;
            BS_SAMPLE: boot_q <= BS_RUN;
            BS_RUN: boot_q <= sw_reset ? BS_RESET : BS_RUN;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_q <= BASE_ADDR;
      end else if (boot_q == BS_SAMPLE) begin
         addr_q <= BASE_ADDR + {3'h0, ~ofs_pin_lvl, 1'b0} + live_q[SYS_SOFT_OFS];
      end
   end
   assign net_addr = addr_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < SYS_FIELDS; i++) begin
            nv_q[i] <= 8'h00;
         end
      end else if (go && cmd.op == OP_SAVE) begin
         nv_q <= live_q;
      end
   end

   // Saved edits take effect fully only after the next boot reloads them; unsaved ones are overwritten
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < SYS_FIELDS; i++) begin
            live_q[i] <= 8'h00;
         end
      end else if (boot_q == BS_RESET) begin
         live_q <= nv_q;
      end else if (go && cmd.op == OP_SYS_WR && cmd.data[10:8] < 3'(SYS_FIELDS)) begin
         live_q[cmd.data[10:8]] <= cmd.data[7:0];
      end
   end

   // ------------------------------------------------------------
   // Program slots
   // ------------------------------------------------------------
   logic [SLOTS-1:0] slot_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_q <= '0;
      end else if (boot_q == BS_RESET) begin
         slot_q[SLOTS-1] <= 1'b0;
      end else if (go && slot_ok(cmd.data)) begin
         if (cmd.op == OP_SLOT_LOAD) begin
            slot_q[slot_bit(cmd.data)] <= 1'b1;
         end else if (cmd.op == OP_SLOT_UNLOAD) begin
            slot_q[slot_bit(cmd.data)] <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Rail settings
   // ------------------------------------------------------------
   logic [31:0] vset_q;
   logic [31:0] ilim_q [2];
   logic [1:0] path_q;
   logic sense_mode_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vset_q <= VSET_RST_UV;
      end else if (go && cmd.op == OP_VSET && on_adj &&
                   in_range(cmd.data, VSET_MIN_UV, VSET_MAX_UV)) begin
         vset_q <= cmd.data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ilim_q[0] <= ILIM_MAX_UA;
         ilim_q[1] <= ILIM_MAX_UA;
      end else if (go && cmd.op == OP_ILIM && cmd.data <= ILIM_MAX_UA) begin
         ilim_q[cmd.rail] <= cmd.data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         path_q <= PATH_AUTO;
      end else if (go && cmd.op == OP_PATH_SET && on_adj &&
                   (cmd.data == 32'(PATH_AUTO) || cmd.data == 32'(PATH_LINEAR) ||
                    cmd.data == 32'(PATH_SWLIN))) begin
         path_q <= cmd.data[1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sense_mode_q <= SENSE_OFF;
      end else if (go && cmd.op == OP_SENSE_SET && on_adj && cmd.data[31:1] == '0) begin
         sense_mode_q <= cmd.data[0];
      end
   end

   // ------------------------------------------------------------
   // Faults and enables
   // ------------------------------------------------------------
   logic [1:0] fault_q;
   logic oc_q;
   logic ot_q;
   logic [1:0] en_q;
   logic [1:0] clr;
   logic oc_trip;
   logic ot_trip;

   assign clr[0] = go && cmd.op == OP_CLEAR && cmd.rail == ADJ;
   assign clr[1] = go && cmd.op == OP_CLEAR && cmd.rail == PASS;
   assign oc_trip = ana.pass_oc && ana.active[PASS];
   assign ot_trip = ana.adj_ot;

   // Cause flags and clear
   // A trip in the clearing cycle wins so no event is lost
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         oc_q <= 1'b0;
         ot_q <= 1'b0;
         fault_q <= 2'b00;
      end else begin
         oc_q <= oc_trip | (oc_q & ~clr[1]);
         ot_q <= ot_trip | (ot_q & ~clr[0]);
         fault_q[PASS] <= oc_trip | (fault_q[PASS] & ~clr[1]);
         fault_q[ADJ] <= ot_trip | (fault_q[ADJ] & ~clr[0]);
      end
   end

   generate
      for (genvar r = 0; r < 2; r++) begin : g_en
         logic trip;
         if (r == 0) begin : g_a
            assign trip = ot_trip;
         end else begin : g_p
            assign trip = oc_trip;
         end
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               en_q[r] <= 1'b0;
            end else if (trip || boot_q != BS_RUN) begin
               en_q[r] <= 1'b0;
            end else if (go && cmd.op == OP_SWITCH && cmd.rail == 1'(r)) begin
               en_q[r] <= cmd.data[0] & ~fault_q[r];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Power stage controls
   // ------------------------------------------------------------
   logic [1:0] drive_q;
   logic sw_q;
   logic hold_q;
   logic disc_q;
   logic sense_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         drive_q <= 2'b00;
         sw_q <= 1'b0;
      end else begin
         drive_q <= en_q;
         unique case (path_q)
            PATH_LINEAR: sw_q <= 1'b0;
            PATH_SWLIN: sw_q <= 1'b1;
            default: sw_q <= ana.vin_high;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_q <= 1'b0;
         disc_q <= 1'b0;
      end else begin
         hold_q <= ana.adj_oc && en_q[ADJ];
         disc_q <= ana.adj_ov;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sense_q <= SENSE_OFF;
      end else begin
         sense_q <= sense_mode_q & ~ana.stage_fault & ~fault_q[ADJ];
      end
   end

   assign rail_drive = drive_q;
   assign vset_uv = vset_q;
   assign ilim_adj_ua = ilim_q[0];
   assign ilim_pass_ua = ilim_q[1];
   assign switcher_en = sw_q;
   assign limit_hold = hold_q;
   assign adj_disconnect = disc_q;
   assign sense_eff = sense_q;

   // ------------------------------------------------------------
   // Status pin
   // ------------------------------------------------------------
   logic stat_oe_q;
   logic stat_o_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_oe_q <= 1'b0;
         stat_o_q <= 1'b1;
      end else begin
         stat_oe_q <= ana.active[ADJ];
         stat_o_q <= 1'b1;
      end
   end
   assign stat_oe = stat_oe_q;
   assign stat_o = stat_o_q;

   // ------------------------------------------------------------
   // Condition word
   // ------------------------------------------------------------
   // Per-rail condition word
   function automatic logic [31:0] cond_word(input logic rail);
      logic [31:0] w;
      w = '0;
      w[ST_INIT] = boot_q == BS_RUN;
      w[ST_EN] = ana.active[rail];
      w[ST_FAULT] = fault_q[rail];
      if (rail == ADJ) begin
         w[ST_HW_LSB +: 8] = sw_q ? ACT_SWLIN : ACT_LINEAR;
         w[ST_OT] = ot_q;
      end else begin
         w[ST_OC] = oc_q;
      end
      return w;
   endfunction : cond_word

   // ------------------------------------------------------------
   // Answers
   // ------------------------------------------------------------
   rss_rsp_t rsp_q;
   logic err;
   logic [31:0] rdat;

   always_comb begin
      err = 1'b0;
      rdat = '0;
      unique case (cmd.op)
         OP_SWITCH: err = cmd.data[0] && fault_q[cmd.rail];
         OP_VSET: err = !on_adj || !in_range(cmd.data, VSET_MIN_UV, VSET_MAX_UV);
         OP_VGET: begin
            err = !on_adj;
            rdat = vset_q;
         end
         OP_ILIM: err = cmd.data > ILIM_MAX_UA;
         OP_ILIM_GET: rdat = ilim_q[cmd.rail];
         OP_PATH_SET: err = !on_adj || !(cmd.data == 32'(PATH_AUTO) ||
                           cmd.data == 32'(PATH_LINEAR) || cmd.data == 32'(PATH_SWLIN));
         OP_PATH_GET: begin
            err = !on_adj;
            rdat = {30'h0, path_q};
         end
         OP_COND: rdat = cond_word(cmd.rail);
         OP_CLEAR, OP_SAVE, OP_SYS_RESET: err = 1'b0;
         OP_SENSE_SET: err = !on_adj || cmd.data[31:1] != '0;
         OP_SENSE_GET: begin
            err = !on_adj;
            rdat = {31'h0, sense_mode_q};
         end
         OP_SENSE_STATE: begin
            err = !on_adj;
            rdat = {31'h0, sense_q};
         end
         OP_SYS_WR, OP_SYS_RD: begin
            err = cmd.data[10:8] >= 3'(SYS_FIELDS);
            if (!err) begin
               rdat = {24'h0, live_q[cmd.data[10:8]]};
            end
         end
         OP_SLOT_LOAD, OP_SLOT_UNLOAD: err = !slot_ok(cmd.data);
         OP_SLOT_STATE: begin
            err = !slot_ok(cmd.data);
            if (!err) begin
               rdat = {31'h0, slot_q[slot_bit(cmd.data)]};
            end
         end
         OP_ADDR_GET: rdat = {24'h0, addr_q};
         default: err = 1'b1;
      endcase
   end

   // Commands arriving while booting are answered with an error
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_q <= '0;
      end else begin
         rsp_q.valid <= cmd.valid;
         rsp_q.err <= cmd.valid && (err || !go);
         rsp_q.data <= go ? rdat : 32'h0000_0000;
      end
   end
   assign rsp = rsp_q;

endmodule : rss_top
`default_nettype wire

// ### verif/rss_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker
// ----
module rss_top_properties
   import rss_pkg::*;
(
   input wire logic clk, // Core clock
   input wire logic resetn, // Async reset
   input wire logic [3:0] ofs_pin_lvl, // Offset pins
   input wire rss_cmd_t cmd, // Command
   input wire rss_ana_t ana, // Monitors
   input wire rss_rsp_t rsp, // Answer
   input wire logic [7:0] net_addr, // Address
   input wire logic [1:0] rail_drive, // Enables
   input wire logic [31:0] vset_uv, // Setpoint
   input wire logic [31:0] ilim_adj_ua, // Limit 0
   input wire logic [31:0] ilim_pass_ua, // Limit 1
   input wire logic switcher_en, // Switcher
   input wire logic limit_hold, // Hold
   input wire logic adj_disconnect, // Disconnect
   input wire logic sense_eff, // Sense
   input wire logic stat_o, // Pin value
   input wire logic stat_oe // Pin enable
);
   logic [2:0] up_q;
   logic run_ok;
   // Boot and reboot take a few edges, so timing checks wait them out
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         up_q <= 3'h0;
      end else if (cmd.valid && cmd.op == OP_SYS_RESET) begin
         up_q <= 3'h0;
      end else if (up_q != 3'h7) begin
         up_q <= up_q + 3'h1;
      end
   end
   assign run_ok = (up_q == 3'h7);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   answer_pulse_a: assert property (cmd.valid |=> rsp.valid)
      else $error("no answer after command");
   pin_high_a: assert property (stat_oe |-> stat_o)
      else $error("status pin driven low");
   pin_follow_a: assert property (run_ok |-> stat_oe == $past(ana.active[0]))
      else $error("status pin not following rail");
   pass_trip_a: assert property (run_ok && ana.pass_oc && ana.active[1]
      |-> ##[1:2] !rail_drive[1]) else $error("pass rail not tripped");
   heat_trip_a: assert property (run_ok && ana.adj_ot |-> ##[1:2] !rail_drive[0])
      else $error("adjustable rail not tripped");
   hold_limit_a: assert property (run_ok |-> limit_hold == $past(ana.adj_oc))
      else $error("current hold wrong");
   ov_disc_a: assert property (run_ok |-> adj_disconnect == $past(ana.adj_ov))
      else $error("disconnect wrong");
   addr_stable_a: assert property (run_ok |=> $stable(net_addr))
      else $error("address moved while running");
   switch_cause_a: assert property (run_ok && $rose(rail_drive[1])
      |-> $past(cmd.valid, 2) && $past(cmd.op, 2) == OP_SWITCH)
      else $error("rail rose without command");
   cover property (ana.pass_oc && rail_drive[1]);
   cover property (rsp.valid && rsp.err);
   cover property ($rose(stat_oe));
endmodule : rss_top_properties
bind rss_top rss_top_properties chk (.clk(clk), .resetn(resetn),
   .ofs_pin_lvl(ofs_pin_lvl), .cmd(cmd), .ana(ana), .rsp(rsp), .net_addr(net_addr),
   .rail_drive(rail_drive), .vset_uv(vset_uv), .ilim_adj_ua(ilim_adj_ua),
   .ilim_pass_ua(ilim_pass_ua), .switcher_en(switcher_en), .limit_hold(limit_hold),
   .adj_disconnect(adj_disconnect), .sense_eff(sense_eff), .stat_o(stat_o),
   .stat_oe(stat_oe));
`default_nettype wire

// ### verif/rss_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Power stage model
// ----
module rss_stage_model
   import rss_pkg::*;
(
   input wire logic clk, // Core clock
   input wire logic slow, // Extra cycle of output lag
   input wire logic [1:0] rail_drive, // Stage enables
   input wire rss_ana_t inj, // Conditions to report
   output rss_ana_t ana // Monitors seen by the block
);
   logic [1:0] on_q;
   logic [1:0] on2_q;
   // output tracks drive, trips only when drive falls
   always_ff @(posedge clk) begin
      on_q <= rail_drive;
      on2_q <= on_q;
   end
   always_comb begin
      ana = inj;
      ana.active = slow ? on2_q : on_q;
   end
endmodule : rss_stage_model
`default_nettype wire

// ### verif/rss_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench
// ----
module rss_top_tb_top
   import rss_pkg::*;
;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] ofs_pin_lvl = 4'he;
   rss_cmd_t cmd = '0;
   rss_ana_t inj = '0;
   logic slow = 1'b0;
   rss_ana_t ana;
   rss_rsp_t rsp;
   logic [7:0] net_addr;
   logic [1:0] rail_drive;
   logic [31:0] vset_uv, ilim_adj_ua, ilim_pass_ua, v;
   logic switcher_en, limit_hold, adj_disconnect, sense_eff, stat_o, stat_oe;
   logic [64:0] exp_q[$];
   logic [31:0] rnd = 32'h7d34;
   int err_total = 0;
   int checks = 0;
   always #4 clk = ~clk;
   rss_top dut (.clk(clk), .resetn(resetn), .ofs_pin_lvl(ofs_pin_lvl), .cmd(cmd),
      .ana(ana), .rsp(rsp), .net_addr(net_addr), .rail_drive(rail_drive),
      .vset_uv(vset_uv), .ilim_adj_ua(ilim_adj_ua), .ilim_pass_ua(ilim_pass_ua),
      .switcher_en(switcher_en), .limit_hold(limit_hold),
      .adj_disconnect(adj_disconnect), .sense_eff(sense_eff), .stat_o(stat_o),
      .stat_oe(stat_oe));
   rss_stage_model stage (.clk(clk), .slow(slow), .rail_drive(rail_drive), .inj(inj),
      .ana(ana));
   function automatic logic [31:0] xs(input logic [31:0] a);
      logic [31:0] x;
      x = a ^ (a << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic results;
      if (err_total == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results
   // Expected answer: error bit, data mask, data
   task automatic send(input rss_op_t op, input logic rl, input logic [31:0] d,
      input logic e, input logic [31:0] m, input logic [31:0] x);
      @(negedge clk);
      cmd = '{1'b1, op, rl, d};
      exp_q.push_back({e, m, x});
   endtask : send
   task automatic idle(input int n);
      @(negedge clk);
      cmd.valid = 1'b0;
      repeat (n) @(negedge clk);
   endtask : idle
   always @(negedge clk) begin
      logic [64:0] e;
      if (rsp.valid === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
         check(32'(rsp.err), 32'(e[64]));
         check(rsp.data & e[63:32], e[31:0]);
      end
   end
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      results();
   end
   initial begin
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      idle(6);
      ofs_pin_lvl = 4'h6;
      idle(2);
      check(32'(net_addr), 32'h8);
      send(OP_ADDR_GET, ADJ, 32'h0, 1'b0, '1, 32'h8);
      send(OP_COND, ADJ, 32'h0, 1'b0, '1, 32'h101);
      for (int p = 0; p < 4; p++) begin
         send(OP_PATH_SET, ADJ, 32'(p), p == 2, 32'h0, 32'h0);
         send(OP_PATH_GET, ADJ, 32'h0, 1'b0, '1, (p == 2) ? 32'h1 : 32'(p));
      end
      send(OP_COND, PASS, 32'h0, 1'b0, '1, 32'h1);
      send(OP_COND, ADJ, 32'h0, 1'b0, '1, 32'h301);
      send(OP_PATH_SET, ADJ, 32'h0, 1'b0, 32'h0, 32'h0);
      inj.vin_high = 1'b1;
      idle(3);
      check(32'(switcher_en), 32'h1);
      inj.vin_high = 1'b0;
      idle(3);
      check(32'(switcher_en), 32'h0);
      rnd = xs(rnd);
      v = rnd % 32'd5000001;
      send(OP_VSET, ADJ, v, 1'b0, 32'h0, 32'h0);
      send(OP_VSET, ADJ, 32'd5000001, 1'b1, 32'h0, 32'h0);
      send(OP_VSET, PASS, v, 1'b1, 32'h0, 32'h0);
      send(OP_VGET, ADJ, 32'h0, 1'b0, '1, v);
      idle(1);
      check(vset_uv, v);
      for (int r = 0; r < 2; r++) begin
         rnd = xs(rnd);
         v = rnd % 32'd3000001;
         send(OP_ILIM, r[0], v, 1'b0, 32'h0, 32'h0);
         send(OP_ILIM, r[0], 32'd3000001, 1'b1, 32'h0, 32'h0);
         send(OP_ILIM_GET, r[0], 32'h0, 1'b0, '1, v);
         idle(1);
         check((r == 0) ? ilim_adj_ua : ilim_pass_ua, v);
      end
      send(rss_op_t'(5'h14), ADJ, 32'h0, 1'b1, 32'h0, 32'h0);
      idle(1);
      check(ilim_pass_ua, v);
      send(OP_SWITCH, ADJ, 32'h1, 1'b0, 32'h0, 32'h0);
      send(OP_SWITCH, PASS, 32'h1, 1'b0, 32'h0, 32'h0);
      idle(5);
      check(32'(rail_drive), 32'h3);
      check(32'({stat_oe, stat_o}), 32'h3);
      send(OP_COND, PASS, 32'h0, 1'b0, '1, 32'h3);
      send(OP_SWITCH, ADJ, 32'h0, 1'b0, 32'h0, 32'h0);
      slow = 1'b1;
      idle(6);
      check(32'(rail_drive), 32'h2);
      check(32'(stat_oe), 32'h0);
      send(OP_SWITCH, ADJ, 32'h1, 1'b0, 32'h0, 32'h0);
      idle(6);
      inj.adj_oc = 1'b1;
      inj.adj_ov = 1'b1;
      idle(3);
      check(32'({limit_hold, adj_disconnect, rail_drive}), 32'hf);
      send(OP_COND, ADJ, 32'h0, 1'b0, '1, 32'h103);
      inj.adj_oc = 1'b0;
      inj.adj_ov = 1'b0;
      send(OP_SENSE_SET, ADJ, 32'h1, 1'b0, 32'h0, 32'h0);
      idle(3);
      check(32'({limit_hold, adj_disconnect, sense_eff}), 32'h1);
      send(OP_SENSE_STATE, ADJ, 32'h0, 1'b0, '1, 32'h1);
      inj.stage_fault = 1'b1;
      idle(3);
      send(OP_SENSE_STATE, ADJ, 32'h0, 1'b0, '1, 32'h0);
      send(OP_SENSE_GET, ADJ, 32'h0, 1'b0, '1, 32'h1);
      inj.stage_fault = 1'b0;
      inj.pass_oc = 1'b1;
      idle(1);
      inj.pass_oc = 1'b0;
      idle(5);
      check(32'(rail_drive), 32'h1);
      send(OP_COND, PASS, 32'h0, 1'b0, '1, 32'h40005);
      send(OP_SWITCH, PASS, 32'h1, 1'b1, 32'h0, 32'h0);
      idle(5);
      check(32'(rail_drive), 32'h1);
      send(OP_CLEAR, PASS, 32'h0, 1'b0, 32'h0, 32'h0);
      send(OP_COND, PASS, 32'h0, 1'b0, '1, 32'h1);
      send(OP_SWITCH, PASS, 32'h1, 1'b0, 32'h0, 32'h0);
      idle(6);
      inj.adj_ot = 1'b1;
      idle(1);
      inj.adj_ot = 1'b0;
      idle(5);
      check(32'({rail_drive, sense_eff}), 32'h4);
      send(OP_COND, ADJ, 32'h0, 1'b0, '1, 32'h200105);
      send(OP_SWITCH, ADJ, 32'h1, 1'b1, 32'h0, 32'h0);
      send(OP_CLEAR, ADJ, 32'h0, 1'b0, 32'h0, 32'h0);
      send(OP_COND, ADJ, 32'h0, 1'b0, '1, 32'h101);
      send(OP_SLOT_LOAD, ADJ, 32'h00b, 1'b0, 32'h0, 32'h0);
      send(OP_SLOT_LOAD, ADJ, 32'h00c, 1'b1, 32'h0, 32'h0);
      send(OP_SLOT_LOAD, ADJ, 32'h100, 1'b0, 32'h0, 32'h0);
      send(OP_SLOT_LOAD, ADJ, 32'h101, 1'b1, 32'h0, 32'h0);
      send(OP_SLOT_STATE, ADJ, 32'h00b, 1'b0, '1, 32'h1);
      send(OP_SLOT_STATE, ADJ, 32'h100, 1'b0, '1, 32'h1);
      for (int f = 0; f < 6; f++) begin
         send(OP_SYS_WR, ADJ, {21'h0, f[2:0], 8'h3}, 1'b0, 32'h0, 32'h0);
         send(OP_SYS_RD, ADJ, {21'h0, f[2:0], 8'h0}, 1'b0, 32'hff, 32'h3);
      end
      send(OP_SAVE, ADJ, 32'h0, 1'b0, 32'h0, 32'h0);
      send(OP_SYS_RESET, ADJ, 32'h0, 1'b0, 32'h0, 32'h0);
      idle(8);
      check(32'(rail_drive), 32'h0);
      send(OP_ADDR_GET, ADJ, 32'h0, 1'b0, '1, 32'h1b);
      send(OP_SYS_RD, ADJ, 32'h0, 1'b0, 32'hff, 32'h3);
      idle(4);
      check(32'(exp_q.size()), 32'h0);
      results();
   end
endmodule : rss_top_tb_top
`default_nettype wire
